// ===== rtl/cmp_unit_pkg.sv
package cmp_unit_pkg;
	// timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int STARTUP_TIME_NS = 1000;
	localparam int STARTUP_CYCLES =
		(STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_CYCLES = 3;

	// register indices, byte address is four times the index
	localparam logic [5:0] IDX_CTRLA = 6'h00;
	localparam logic [5:0] IDX_CTRLB = 6'h01;
	localparam logic [5:0] IDX_EVCTRL = 6'h02;
	localparam logic [5:0] IDX_IEN_CLR = 6'h04;
	localparam logic [5:0] IDX_IEN_SET = 6'h05;
	localparam logic [5:0] IDX_IRQ_FLAG = 6'h06;
	localparam logic [5:0] IDX_STATUSA = 6'h08;
	localparam logic [5:0] IDX_STATUSB = 6'h09;
	localparam logic [5:0] IDX_STATUSC = 6'h0A;
	localparam logic [5:0] IDX_WINDOW_CONTROL_REG = 6'h0C;
	localparam logic [5:0] IDX_CMPCTRL0 = 6'h10;
	localparam logic [5:0] IDX_CMPCTRL1 = 6'h14;

	// field positions
	localparam int CTRLA_SOFT_RST = 0;
	localparam int CTRLA_ENABLE = 1;
	localparam int CTRLA_RUN_STDBY = 2;
	localparam int EV_CMP_OUT_EN0 = 0;
	localparam int EV_WIN_OUT_EN = 4;
	localparam int EV_CMP_IN_EN0 = 8;
	localparam int STATB_SYNC_BUSY = 7;
	localparam int CC_ENABLE = 0;
	localparam int CC_SINGLE = 1;
	localparam int CC_CMP_IRQ_CONDITION_SEL_LO = 5;
	localparam int WIN_ENABLE = 0;
	localparam int WIN_CMP_IRQ_CONDITION_SEL_LO = 1;

	// writable masks and reset values
	localparam logic [7:0] CTRLA_MASK = 8'h86;
	localparam logic [15:0] EVCTRL_MASK = 16'h0313;
	localparam logic [31:0] CMPCTRL_MASK = 32'h070B_B76F;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;

	// comparator interrupt conditions
	localparam logic [1:0] CMP_IRQ_CONDITION_SEL_TOGGLE = 2'h0;
	localparam logic [1:0] CMP_IRQ_CONDITION_SEL_RISE = 2'h1;
	localparam logic [1:0] CMP_IRQ_CONDITION_SEL_FALL = 2'h2;
	localparam logic [1:0] CMP_IRQ_CONDITION_SEL_EOC = 2'h3;

	// window states and interrupt conditions
	localparam logic [1:0] WSTATE_ABOVE = 2'h0;
	localparam logic [1:0] WSTATE_INSIDE = 2'h1;
	localparam logic [1:0] WSTATE_BELOW = 2'h2;
	localparam logic [1:0] WINDOW_IRQ_CONDITION_SEL_ABOVE = 2'h0;
	localparam logic [1:0] WINDOW_IRQ_CONDITION_SEL_INSIDE = 2'h1;
	localparam logic [1:0] WINDOW_IRQ_CONDITION_SEL_BELOW = 2'h2;
	localparam logic [1:0] WINDOW_IRQ_CONDITION_SEL_OUTSIDE = 2'h3;

	typedef enum logic [2:0] {
		SS_IDLE = 3'h1,
		SS_WAIT = 3'h2,
		SS_CMP = 3'h4
	} ss_state_t;
endpackage

// ===== rtl/comparator_unit_ctrl.sv
`timescale 1ns/1ps
// What this block does
// (R1) each comparator has its own interrupt source able to wake from sleep
// (R2) window pair has its own interrupt source able to wake from sleep
// (R3) comparator interrupt fires only on its selected condition
// (R4) window interrupt fires only on its two-bit selected condition
// (R5) each source sets its own flag when its condition occurs
// (R6) one to enable-set enables, one to enable-clear disables, zero nothing
// (R7) request is high while flag and enable are both set
// (R8) writing one to a flag clears it, zero leaves it
// (R9) output events only while their event-output enable is one
// (R10) input events act only while their event-input enable is one
// (R11) accepted input event starts single-shot after start-up delay
// (R12) window mode: either event starts both comparators together
// (R13) without run-in-standby, standby powers off; start-up delay on leaving
// (R14) with run-in-standby, comparators run and enabled sources wake
// (R15) while sleeping, only events start single-shots, not register writes
// (R16) continuous stays powered; single-shot powered only when triggered
// (R17) continuous edge matching condition requests the digital clock
// (R18) after edge: wake if enabled, else release clock; no filtering
// (R19) sleep event: clock, power, wait, compare, signal, then power down
// (R20) synchronized operation sets busy at once, clears when done
// (R21) synchronized access while busy stalls the bus, never lost
// (R22) soft reset, enable, comparator enables and window control sync
// (R23) window event follows window state whatever the interrupt enable
// (R24) start bit acts only in enabled single-shot mode, reads zero
// (R25) hardware flag set wins over a same-cycle software clear
module comparator_unit_ctrl #(
	parameter int STARTUP_CYC = cmp_unit_pkg::STARTUP_CYCLES,
	parameter int SYNC_CYC = cmp_unit_pkg::SYNC_CYCLES
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_in,
	// wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// comparator and system side
	input wire logic [1:0] cmp_result_in,
	input wire logic [1:0] event_in,
	input wire logic sleep_in,
	input wire logic standby_in,
	// requests and events
	output logic irq_out,
	output logic [1:0] cmp_event_out,
	output logic win_event_out,
	output logic [1:0] cmp_power_out,
	output logic dig_clk_req_out,
	output logic wake_out
);
	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic [7:0] ctrla;
		logic en_act;
		logic soft_reset_bit;
		logic [15:0] evctrl;
		logic [2:0] ien;
		logic [2:0] flag;
		logic [2:0] window_control_reg;
		logic [2:0] win_act;
		logic [1:0][31:0] cc;
		logic [1:0] cen_act;
		logic [3:0] sync_cnt;
		logic [1:0] res;
		logic [1:0] wstate;
		cmp_unit_pkg::ss_state_t [1:0] ss;
		logic [1:0][7:0] su;
		logic irq;
		logic [1:0] cev;
		logic wev;
		logic [1:0] pwr;
		logic clkreq;
		logic wake;
	} state_t;

	state_t q_ff;
	state_t nxt_q;
	logic [5:0] idx;
	logic busy, synced, stall, take, wr, off_stby;
	logic [1:0] start_wr, trig_raw, trig, cmp_cond, newres, on, single;
	logic [1:0] ready;
	logic [2:0] fl_set, fl_clr;
	logic [1:0] wnew;
	logic win_chg, win_cond;
	logic [31:0] d;

	function automatic logic [31:0] bmerge(input logic [31:0] o,
		input logic [31:0] v, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[b*8 +: 8] = v[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] pack3(input logic [2:0] x);
		return {27'h000_0000, x[2], 2'h0, x[1:0]};
	endfunction

	// comparator condition match
	function automatic logic hit(input logic [1:0] sel, input logic o,
		input logic v, input logic eoc);
		logic h;
		h = 1'b0;
		unique case (sel)
			cmp_unit_pkg::CMP_IRQ_CONDITION_SEL_TOGGLE: h = o ^ v;
			cmp_unit_pkg::CMP_IRQ_CONDITION_SEL_RISE: h = !o & v;
			cmp_unit_pkg::CMP_IRQ_CONDITION_SEL_FALL: h = o & !v;
			cmp_unit_pkg::CMP_IRQ_CONDITION_SEL_EOC: h = eoc;
		endcase
		return h;
	endfunction

	function automatic state_t rst_state();
		state_t s;
		s = '0;
		s.ss[0] = cmp_unit_pkg::SS_IDLE;
		s.ss[1] = cmp_unit_pkg::SS_IDLE;
		s.su = {8'(STARTUP_CYC), 8'(STARTUP_CYC)};
		return s;
	endfunction

	always_comb begin
		nxt_q = q_ff;
		d = wb_dat_in;
		idx = wb_adr_in[7:2];
		busy = q_ff.sync_cnt != 4'h0;
		// synchronized write targets
		synced = wb_we_in & wb_sel_in[0] & ((idx == cmp_unit_pkg::IDX_CTRLA)
			| (idx == cmp_unit_pkg::IDX_WINDOW_CONTROL_REG)
			| (idx == cmp_unit_pkg::IDX_CMPCTRL0)
			| (idx == cmp_unit_pkg::IDX_CMPCTRL1)); // R22
		stall = synced & busy; // R21
		take = wb_cyc_in & wb_stb_in & !q_ff.ack & !stall; // R21
		wr = take & wb_we_in;
		nxt_q.ack = take;
		fl_clr = 3'h0;
		start_wr = 2'h0;
		off_stby = standby_in & !q_ff.ctrla[cmp_unit_pkg::CTRLA_RUN_STDBY];
		for (int i = 0; i < 2; i++) begin
			single[i] = q_ff.cc[i][cmp_unit_pkg::CC_SINGLE];
			on[i] = q_ff.en_act & q_ff.cen_act[i] & !off_stby; // R13
			ready[i] = on[i] & (single[i] | (q_ff.su[i] == 8'h00));
		end
		// sync countdown, commit at the end
		if (busy) begin
			nxt_q.sync_cnt = q_ff.sync_cnt - 4'h1; // R20
			if (q_ff.sync_cnt == 4'h1) begin
				nxt_q.en_act = q_ff.ctrla[cmp_unit_pkg::CTRLA_ENABLE];
				nxt_q.cen_act = {q_ff.cc[1][cmp_unit_pkg::CC_ENABLE],
					q_ff.cc[0][cmp_unit_pkg::CC_ENABLE]};
				nxt_q.win_act = q_ff.window_control_reg;
			end
		end
		// read mux
		nxt_q.rdat = cmp_unit_pkg::REG_RESET;
		if (take & !wb_we_in) begin
			unique case (idx)
				cmp_unit_pkg::IDX_CTRLA: nxt_q.rdat = {24'h00_0000,
					q_ff.ctrla[7:1], q_ff.soft_reset_bit};
				cmp_unit_pkg::IDX_EVCTRL: nxt_q.rdat = {16'h0000,
					q_ff.evctrl};
				cmp_unit_pkg::IDX_IEN_CLR: nxt_q.rdat = pack3(q_ff.ien);
				cmp_unit_pkg::IDX_IEN_SET: nxt_q.rdat = pack3(q_ff.ien);
				cmp_unit_pkg::IDX_IRQ_FLAG: nxt_q.rdat = pack3(q_ff.flag);
				cmp_unit_pkg::IDX_STATUSA: nxt_q.rdat = {26'h000_0000,
					q_ff.wstate, 2'h0, q_ff.res};
				cmp_unit_pkg::IDX_STATUSC: nxt_q.rdat = {26'h000_0000,
					q_ff.wstate, 2'h0, q_ff.res};
				cmp_unit_pkg::IDX_STATUSB: nxt_q.rdat = {24'h00_0000,
					busy, 5'h00, ready};
				cmp_unit_pkg::IDX_WINDOW_CONTROL_REG: nxt_q.rdat = {29'h0000_0000,
					q_ff.window_control_reg};
				cmp_unit_pkg::IDX_CMPCTRL0: nxt_q.rdat = q_ff.cc[0];
				cmp_unit_pkg::IDX_CMPCTRL1: nxt_q.rdat = q_ff.cc[1];
				default: nxt_q.rdat = cmp_unit_pkg::REG_RESET;
			endcase
		end
		// register writes
		if (wr) begin
			unique case (idx)
				cmp_unit_pkg::IDX_CTRLA: if (wb_sel_in[0]) begin
					if (d[cmp_unit_pkg::CTRLA_SOFT_RST]) begin
						nxt_q.soft_reset_bit = 1'b1;
					end else begin
						nxt_q.ctrla = d[7:0] & cmp_unit_pkg::CTRLA_MASK;
					end
					nxt_q.sync_cnt = 4'(SYNC_CYC); // R20
				end
				cmp_unit_pkg::IDX_CTRLB: if (wb_sel_in[0] & !sleep_in) begin
					start_wr = d[1:0]; // R15
				end
				cmp_unit_pkg::IDX_EVCTRL: nxt_q.evctrl = 16'(bmerge(
					{16'h0000, q_ff.evctrl}, d, wb_sel_in))
					& cmp_unit_pkg::EVCTRL_MASK;
				cmp_unit_pkg::IDX_IEN_CLR: if (wb_sel_in[0]) begin
					nxt_q.ien = q_ff.ien & ~{d[4], d[1:0]}; // R6
				end
				cmp_unit_pkg::IDX_IEN_SET: if (wb_sel_in[0]) begin
					nxt_q.ien = q_ff.ien | {d[4], d[1:0]}; // R6
				end
				cmp_unit_pkg::IDX_IRQ_FLAG: if (wb_sel_in[0]) begin
					fl_clr = {d[4], d[1:0]}; // R8
				end
				cmp_unit_pkg::IDX_WINDOW_CONTROL_REG: if (wb_sel_in[0]) begin
					nxt_q.window_control_reg = d[2:0];
					nxt_q.sync_cnt = 4'(SYNC_CYC); // R20
				end
				cmp_unit_pkg::IDX_CMPCTRL0: begin
					nxt_q.cc[0] = bmerge(q_ff.cc[0], d, wb_sel_in)
						& cmp_unit_pkg::CMPCTRL_MASK;
					if (wb_sel_in[0]) begin
						nxt_q.sync_cnt = 4'(SYNC_CYC); // R20
					end
				end
				cmp_unit_pkg::IDX_CMPCTRL1: begin
					nxt_q.cc[1] = bmerge(q_ff.cc[1], d, wb_sel_in)
						& cmp_unit_pkg::CMPCTRL_MASK;
					if (wb_sel_in[0]) begin
						nxt_q.sync_cnt = 4'(SYNC_CYC); // R20
					end
				end
				default: nxt_q.rdat = cmp_unit_pkg::REG_RESET;
			endcase
		end
		// triggers
		for (int i = 0; i < 2; i++) begin
			trig_raw[i] = (event_in[i]
				& q_ff.evctrl[cmp_unit_pkg::EV_CMP_IN_EN0 + i])
				| start_wr[i]; // R10
		end
		if (q_ff.win_act[cmp_unit_pkg::WIN_ENABLE]) begin
			trig = {2{|trig_raw}}; // R12
		end else begin
			trig = trig_raw; // R12
		end
		// per comparator sequencing
		for (int i = 0; i < 2; i++) begin
			newres[i] = q_ff.res[i];
			cmp_cond[i] = 1'b0;
			if (single[i]) begin
				unique case (q_ff.ss[i])
					cmp_unit_pkg::SS_IDLE: if (on[i] & trig[i]) begin
						nxt_q.ss[i] = cmp_unit_pkg::SS_WAIT; // R24
						nxt_q.su[i] = 8'(STARTUP_CYC); // R11
					end
					cmp_unit_pkg::SS_WAIT: if (!on[i]) begin
						nxt_q.ss[i] = cmp_unit_pkg::SS_IDLE;
					end else if (q_ff.su[i] <= 8'h01) begin
						nxt_q.ss[i] = cmp_unit_pkg::SS_CMP; // R11
						nxt_q.su[i] = 8'h00;
					end else begin
						nxt_q.su[i] = q_ff.su[i] - 8'h01; // R19
					end
					cmp_unit_pkg::SS_CMP: begin
						newres[i] = cmp_result_in[i];
						cmp_cond[i] = hit(q_ff.cc[i][
							cmp_unit_pkg::CC_CMP_IRQ_CONDITION_SEL_LO +: 2],
							q_ff.res[i], newres[i], 1'b1); // R3
						nxt_q.ss[i] = cmp_unit_pkg::SS_IDLE; // R19
					end
				endcase
			end else begin
				nxt_q.ss[i] = cmp_unit_pkg::SS_IDLE;
				if (!on[i]) begin
					nxt_q.su[i] = 8'(STARTUP_CYC); // R13
				end else if (q_ff.su[i] != 8'h00) begin
					nxt_q.su[i] = q_ff.su[i] - 8'h01; // R13
				end else begin
					newres[i] = cmp_result_in[i]; // R18
					cmp_cond[i] = hit(q_ff.cc[i][
						cmp_unit_pkg::CC_CMP_IRQ_CONDITION_SEL_LO +: 2],
						q_ff.res[i], newres[i], 1'b0); // R17
				end
			end
			nxt_q.res[i] = newres[i];
			nxt_q.pwr[i] = (on[i] & !single[i])
				| (q_ff.ss[i] != cmp_unit_pkg::SS_IDLE)
				| (nxt_q.ss[i] != cmp_unit_pkg::SS_IDLE); // R16
			nxt_q.cev[i] = cmp_cond[i]
				& q_ff.evctrl[cmp_unit_pkg::EV_CMP_OUT_EN0 + i]; // R9
		end
		// window state, cmp0 upper limit, cmp1 lower limit
		if (newres[0]) begin
			wnew = cmp_unit_pkg::WSTATE_ABOVE;
		end else if (newres[1]) begin
			wnew = cmp_unit_pkg::WSTATE_INSIDE;
		end else begin
			wnew = cmp_unit_pkg::WSTATE_BELOW;
		end
		nxt_q.wstate = wnew;
		win_chg = q_ff.win_act[cmp_unit_pkg::WIN_ENABLE]
			& (wnew != q_ff.wstate);
		win_cond = 1'b0;
		unique case (q_ff.win_act[cmp_unit_pkg::WIN_CMP_IRQ_CONDITION_SEL_LO +: 2])
			cmp_unit_pkg::WINDOW_IRQ_CONDITION_SEL_ABOVE:
				win_cond = wnew == cmp_unit_pkg::WSTATE_ABOVE; // R4
			cmp_unit_pkg::WINDOW_IRQ_CONDITION_SEL_INSIDE:
				win_cond = wnew == cmp_unit_pkg::WSTATE_INSIDE; // R4
			cmp_unit_pkg::WINDOW_IRQ_CONDITION_SEL_BELOW:
				win_cond = wnew == cmp_unit_pkg::WSTATE_BELOW; // R4
			cmp_unit_pkg::WINDOW_IRQ_CONDITION_SEL_OUTSIDE:
				win_cond = q_ff.wstate == cmp_unit_pkg::WSTATE_INSIDE; // R4
		endcase
		win_cond = win_cond & win_chg;
		nxt_q.wev = win_chg & q_ff.evctrl[cmp_unit_pkg::EV_WIN_OUT_EN]; // R23
		// flags, set beats clear
		fl_set = {win_cond, cmp_cond}; // R5
		nxt_q.flag = (q_ff.flag & ~fl_clr) | fl_set; // R25
		nxt_q.irq = |(nxt_q.flag & nxt_q.ien); // R7
		nxt_q.wake = (sleep_in | standby_in) & nxt_q.irq; // R1 R2 R14
		nxt_q.clkreq = !standby_in | busy | (|nxt_q.pwr & (|single))
			| (|fl_set) | nxt_q.wake; // R17 R18 R19
		if (reset_in | (q_ff.soft_reset_bit & (q_ff.sync_cnt == 4'h1))) begin
			nxt_q = rst_state(); // R22
		end
	end

	always_ff @(posedge sys_clk_in) begin
		q_ff <= nxt_q;
	end

	assign wb_dat_out = q_ff.rdat;
	assign wb_ack_out = q_ff.ack;
	assign irq_out = q_ff.irq;
	assign cmp_event_out = q_ff.cev;
	assign win_event_out = q_ff.wev;
	assign cmp_power_out = q_ff.pwr;
	assign dig_clk_req_out = q_ff.clkreq;
	assign wake_out = q_ff.wake;

	// checks
	a_irq_level: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		irq_out == |(q_ff.flag & q_ff.ien)) // R7
		else $error("irq does not follow flag and enable");
	a_flag_clear: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		(wr && idx == cmp_unit_pkg::IDX_IRQ_FLAG && wb_sel_in[0] && d[0]
		&& !fl_set[0]) |=> !q_ff.flag[0]) // R8
		else $error("flag not cleared by one write");
	a_set_wins: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		fl_set[0] |=> q_ff.flag[0] ##1 irq_out == (q_ff.flag[0]
		& q_ff.ien[0]) | (|(q_ff.flag[2:1] & q_ff.ien[2:1]))) // R25
		else $error("flag set lost");
	a_ien_set: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		(wr && idx == cmp_unit_pkg::IDX_IEN_SET && wb_sel_in[0] && d[1])
		|=> q_ff.ien[1]) // R6
		else $error("enable set failed");
	a_ien_zero: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		(wr && idx == cmp_unit_pkg::IDX_IEN_CLR && d[4] == 1'b0
		&& d[1:0] == 2'h0) |=> $stable(q_ff.ien)) // R6
		else $error("zero write changed enables");
	a_busy_now: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		(take && synced) |=> q_ff.sync_cnt != 4'h0) // R20
		else $error("busy not set at once");
	a_busy_ends: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		$rose(q_ff.sync_cnt != 4'h0) |-> ##[1:8] q_ff.sync_cnt == 4'h0) // R20
		else $error("busy never clears");
	a_stall_busy: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		(wb_cyc_in && wb_stb_in && synced && busy) |=> !wb_ack_out) // R21
		else $error("synced access acked while busy");
	a_evout_gate: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		cmp_event_out[0] |-> $past(q_ff.evctrl[0])) // R9
		else $error("event out while disabled");
	a_start_sleep: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		(sleep_in && trig_raw == 2'h0) |=> $stable(q_ff.ss)
		|| q_ff.ss[0] != cmp_unit_pkg::SS_WAIT) // R15
		else $error("register start while sleeping");
	c_cont_flag: cover property (@(posedge sys_clk_in) disable iff (reset_in)
		!single[0] && fl_set[0]);
	c_ss_done: cover property (@(posedge sys_clk_in) disable iff (reset_in)
		q_ff.ss[0] == cmp_unit_pkg::SS_CMP ##1 cmp_event_out[0]);
	c_stall: cover property (@(posedge sys_clk_in) disable iff (reset_in)
		stall ##1 !stall && take);
	c_win: cover property (@(posedge sys_clk_in) disable iff (reset_in)
		win_event_out);
endmodule

// ===== verif/cmp_far_model.sv
`timescale 1ns/1ps
// far side: event routing and comparator analog outputs
module cmp_far_model (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_in,
	// commands from the bench
	input wire logic [1:0] fire_in,
	input wire logic [1:0] level_in,
	// toward the block
	output logic [1:0] event_out,
	output logic [1:0] result_out
);
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			event_out <= 2'h0;
			result_out <= 2'h0;
		end else begin
			// one-cycle event pulses, low between events
			event_out <= fire_in;
			result_out <= level_in;
		end
	end
endmodule

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
	localparam int LIMIT = 20000;
	logic sys_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	logic ack;
	logic [1:0] lvl = 2'h0;
	logic [1:0] fire = 2'h0;
	logic [1:0] res;
	logic [1:0] evt;
	logic sleep = 1'b0;
	logic stdby = 1'b0;
	logic irq;
	logic [1:0] cmp_ev;
	logic win_ev;
	logic [1:0] pwr;
	logic clk_req;
	logic wake;
	logic [31:0] q;
	int error_cnt = 0;
	int samples_checked = 0;
	int cyc_cnt = 0;
	int ev0_cnt = 0;

	always #12.5 sys_clk_in = ~sys_clk_in;

	comparator_unit_ctrl #(.STARTUP_CYC(4), .SYNC_CYC(3)) dut_u (
		.sys_clk_in(sys_clk_in), .reset_in(reset_in),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
		.wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
		.wb_dat_out(rdat), .wb_ack_out(ack),
		.cmp_result_in(res), .event_in(evt),
		.sleep_in(sleep), .standby_in(stdby),
		.irq_out(irq), .cmp_event_out(cmp_ev), .win_event_out(win_ev),
		.cmp_power_out(pwr), .dig_clk_req_out(clk_req), .wake_out(wake)
	);

	cmp_far_model far_u (
		.sys_clk_in(sys_clk_in), .reset_in(reset_in),
		.fire_in(fire), .level_in(lvl),
		.event_out(evt), .result_out(res)
	);

	task automatic close_out();
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	always @(posedge sys_clk_in) begin
		cyc_cnt++;
		if (cmp_ev[0] === 1'b1) begin
			ev0_cnt++;
		end
		if (cyc_cnt == LIMIT) begin
			error_cnt++;
			close_out();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// classic cycle; holds until ack is sampled high
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		wdat <= d;
		do begin
			@(posedge sys_clk_in);
			n++;
		end while (ack !== 1'b1 && n < 200);
		q = rdat;
		if (n >= 200) begin
			error_cnt++;
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge sys_clk_in);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0000_0000);
		chk(q, e);
	endtask

	task automatic pause(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask

	task automatic pulse(input logic [1:0] m);
		fire <= m;
		@(posedge sys_clk_in);
		fire <= 2'h0;
		pause(20);
	endtask

	initial begin
		pause(20);
		reset_in <= 1'b0;
		@(posedge sys_clk_in);
		rd_chk(8'h00, 32'h0000_0000);
		rd_chk(8'h08, 32'h0000_0000);
		wr(8'h7C, 32'hFFFF_FFFF);
		rd_chk(8'h7C, 32'h0000_0000);
		wr(8'h00, 32'h0000_0002);
		xfer(1'b0, 8'h24, 32'h0000_0000);
		chk({31'h0, q[7]}, 32'h0000_0001);
		wr(8'h40, 32'h0000_0021);
		rd_chk(8'h40, 32'h0000_0021);
		wr(8'h14, 32'h0000_0001);
		wr(8'h08, 32'h0000_0001);
		pause(20);
		ev0_cnt = 0;
		lvl <= 2'h1;
		pause(10);
		rd_chk(8'h18, 32'h0000_0001);
		chk({31'h0, irq}, 32'h0000_0001);
		chk(ev0_cnt, 32'h0000_0001);
		wr(8'h18, 32'h0000_0001);
		rd_chk(8'h18, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0000_0000);
		lvl <= 2'h0;
		pause(10);
		rd_chk(8'h18, 32'h0000_0000);
		lvl <= 2'h1;
		pause(10);
		wr(8'h18, 32'h0000_0000);
		rd_chk(8'h18, 32'h0000_0001);
		wr(8'h10, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0000_0001);
		wr(8'h10, 32'h0000_0001);
		chk({31'h0, irq}, 32'h0000_0000);
		wr(8'h14, 32'h0000_0001);
		sleep <= 1'b1;
		pause(3);
		chk({31'h0, wake}, 32'h0000_0001);
		sleep <= 1'b0;
		wr(8'h08, 32'h0000_0000);
		wr(8'h18, 32'h0000_0001);
		lvl <= 2'h0;
		pause(5);
		ev0_cnt = 0;
		lvl <= 2'h1;
		pause(10);
		chk(ev0_cnt, 32'h0000_0000);
		rd_chk(8'h18, 32'h0000_0001);
		wr(8'h50, 32'h0000_0063);
		pause(20);
		wr(8'h18, 32'h0000_0013);
		pulse(2'h2);
		rd_chk(8'h18, 32'h0000_0000);
		wr(8'h08, 32'h0000_0200);
		pulse(2'h2);
		rd_chk(8'h18, 32'h0000_0002);
		chk({30'h0000_0000, pwr}, 32'h0000_0001);
		wr(8'h18, 32'h0000_0002);
		sleep <= 1'b1;
		wr(8'h04, 32'h0000_0002);
		pause(20);
		rd_chk(8'h18, 32'h0000_0000);
		sleep <= 1'b0;
		wr(8'h04, 32'h0000_0002);
		pause(20);
		rd_chk(8'h18, 32'h0000_0002);
		rd_chk(8'h04, 32'h0000_0000);
		wr(8'h30, 32'h0000_0003);
		rd_chk(8'h30, 32'h0000_0003);
		wr(8'h00, 32'h0000_0001);
		pause(10);
		rd_chk(8'h00, 32'h0000_0000);
		rd_chk(8'h50, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0000_0000);
		close_out();
	end
endmodule
